//--- inc/tempseq_defines.svh
// register map, field positions and constants of the temperature ratio sequencer
// Operation
// - reference discharge through both gauges in parallel
// - second discharge through gauge plus resistor branches
// - drive bridge switches for each discharge route
// - combine both discharges into resistor-over-gauge ratio
// - measurement runs only while enable bit set
// - one select bit picks both resistor values
// - one temperature measurement at cycle end
// - ratio updated with results, read at 245
// - word holds ratio minus one times 2^20
// - both on-chip resistors identical, one setting
// - enable picks internal or external span sensor
// - drift correction only while correction bit set
`ifndef TEMPSEQ_DEFINES_SVH
`define TEMPSEQ_DEFINES_SVH

`define ADR_W 12
`define IDX_CFG1 8'h01
`define IDX_CFG8 8'h08
`define IDX_CFG9 8'h09
`define IDX_CFG14 8'h0e
`define IDX_RESULT 8'hf5
`define IDX_STATUS 8'hf6

`define CFG1_CORR_EN_BIT 6
`define CFG1_ONCHIP_EN_BIT 8
`define CFG14_LOW_SEL_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_VALID_BIT 1
`define STAT_SAT_BIT 2

`define CFG_RESET 24'h000000
`define RESULT_RESET 24'h000000
`define RATIO_FRAC_BITS 20

`endif

//--- inc/tempseq_pkg.sv
// types shared by the temperature ratio sequencer modules
package tempseq_pkg;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_REF   = 5'b00010,
        ST_SER   = 5'b00100,
        ST_DIV   = 5'b01000,
        ST_STORE = 5'b10000
    } seq_state_e;

    typedef enum logic [2:0] {
        ROUTE_OPEN = 3'b001,
        ROUTE_REF  = 3'b010,
        ROUTE_SER  = 3'b100
    } route_e;

    typedef struct packed {
        logic c_direct;
        logic d_direct;
        logic c_series;
        logic d_series;
    } switch_set_s;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

endpackage

//--- core/tempseq_ratio_div.sv
// restoring divider for the temperature ratio, saturating quotient
`timescale 1ns/1ps
module tempseq_ratio_div #(
    parameter int NW = 44,
    parameter int DW = 24,
    parameter int QW = 24
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // operands
    input wire logic start,
    input wire logic [NW-1:0] numer,
    input wire logic [DW-1:0] denom,
    // result
    output logic done,
    output logic [QW-1:0] quot,
    output logic sat
);
    localparam int CW = $clog2(NW + 1);

    logic [NW-1:0] num_r;
    logic [NW-1:0] q_r;
    logic [DW-1:0] den_r;
    logic [DW:0] rem_r;
    logic [DW:0] rem_shift;
    logic [CW-1:0] cnt_r;
    logic busy_r;
    logic fin_r;
    logic fits;

    assign rem_shift = {rem_r[DW-1:0], num_r[NW-1]};
    assign fits = rem_shift >= {1'b0, den_r};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            num_r <= '0;
            q_r <= '0;
            den_r <= '0;
            rem_r <= '0;
            cnt_r <= '0;
            busy_r <= 1'b0;
            fin_r <= 1'b0;
        end else if (start) begin
            num_r <= numer;
            q_r <= '0;
            den_r <= denom;
            rem_r <= '0;
            cnt_r <= CW'(NW);
            busy_r <= 1'b1;
            fin_r <= 1'b0;
        end else begin
            fin_r <= busy_r && (cnt_r == CW'(1));
            if (busy_r) begin
                num_r <= {num_r[NW-2:0], 1'b0};
                rem_r <= fits ? rem_shift - {1'b0, den_r} : rem_shift;
                q_r <= {q_r[NW-2:0], fits};
                cnt_r <= cnt_r - CW'(1);
                busy_r <= cnt_r != CW'(1);
            end
        end
    end

    // zero denominator yields all ones and lands here too
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            done <= 1'b0;
            quot <= '0;
            sat <= 1'b0;
        end else begin
            done <= fin_r;
            if (fin_r) begin
                quot <= (|q_r[NW-1:QW]) ? '1 : q_r[QW-1:0];
                sat <= (|q_r[NW-1:QW]) || (den_r == '0);
            end
        end
    end
endmodule

//--- core/tempseq_switch_drive.sv
// bridge port switch driver with break-before-make between routes
`timescale 1ns/1ps
module tempseq_switch_drive (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // requested route
    input wire tempseq_pkg::route_e route,
    // switch drive and route now in effect
    output tempseq_pkg::switch_set_s switches,
    output tempseq_pkg::route_e applied
);
    import tempseq_pkg::*;

    route_e last_r;

    function automatic switch_set_s route_switches(route_e r);
        switch_set_s s;
        s = '0;
        unique case (r)
            ROUTE_OPEN: s = '0;
            ROUTE_REF: begin
                s.c_direct = 1'b1;
                s.d_direct = 1'b1;
            end
            ROUTE_SER: begin
                s.c_series = 1'b1;
                s.d_series = 1'b1;
            end
        endcase
        return s;
    endfunction

    // one cycle all open whenever the route changes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            last_r <= ROUTE_OPEN;
            switches <= '0;
            applied <= ROUTE_OPEN;
        end else begin
            last_r <= route;
            if (route != last_r) begin
                switches <= '0;
                applied <= ROUTE_OPEN;
            end else begin
                switches <= route_switches(route);
                applied <= route;
            end
        end
    end
endmodule

//--- core/onchip_temperature_ratio_sequencer.sv
// temperature ratio sequencer: wishbone registers, discharge sequencing, result store
`timescale 1ns/1ps
`include "tempseq_defines.svh"
module onchip_temperature_ratio_sequencer #(
    parameter int TW = 24,
    parameter int RW = 24
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register bus
    input wire tempseq_pkg::wb_req_s wb_req,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // converter cycle timing
    input wire logic cycle_end,
    input wire logic discharge_done,
    input wire logic [TW-1:0] discharge_time,
    output logic discharge_start,
    output logic results_update,
    // analog switches and resistor select
    output tempseq_pkg::switch_set_s switches,
    output logic temp_resistor_low_select,
    // compensation controls and result
    output logic onchip_temp_select,
    output logic temp_correction_en,
    output logic [23:0] gain_drift_factor,
    output logic [23:0] offset_drift_factor,
    output logic [RW-1:0] temp_result
);
    import tempseq_pkg::*;

    localparam int NW = TW + `RATIO_FRAC_BITS;

    // configuration
    logic onchip_en_r;
    logic corr_en_r;
    logic low_sel_r;
    logic [23:0] gain_r;
    logic [23:0] offset_r;
    logic [23:0] cfg1_word;
    logic [23:0] cfg14_word;
    logic [23:0] cfg1_merged;
    logic [23:0] cfg14_merged;
    // sequencer
    seq_state_e state_r;
    seq_state_e state_nxt;
    route_e route_r;
    route_e applied;
    logic started_r;
    logic fire;
    logic [TW-1:0] t_ref_r;
    logic [TW-1:0] t_ser_r;
    logic [TW-1:0] diff;
    logic [NW-1:0] numer;
    logic div_start_r;
    logic div_done;
    logic div_sat;
    logic [RW-1:0] div_quot;
    // results and outputs
    logic [RW-1:0] result_r;
    logic valid_r;
    logic sat_r;
    logic update_r;
    logic start_r;
    logic sel_out_r;
    logic corr_out_r;
    logic low_out_r;
    logic [23:0] gain_out_r;
    logic [23:0] offset_out_r;
    // bus
    logic bus_req;
    logic wr_req;
    logic [31:0] rd_data;
    logic [31:0] dat_r;
    logic ack_r;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    function automatic logic reg_hit(logic [`ADR_W-1:0] adr, logic [7:0] idx);
        return (adr[`ADR_W-1:10] == '0) && (adr[9:2] == idx);
    endfunction

    function automatic logic [23:0] merge_bytes(logic [23:0] old, logic [31:0] dat,
                                                logic [3:0] sel);
        logic [23:0] res;
        res = old;
        for (int i = 0; i < 3; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign bus_req = wb_req.cyc && wb_req.stb && !ack_r;
    // a write lands at the edge where the master sees ack
    assign wr_req = wb_req.cyc && wb_req.stb && wb_req.we && ack_r;
    assign cfg1_merged = merge_bytes(cfg1_word, wb_req.dat, wb_req.sel);
    assign cfg14_merged = merge_bytes(cfg14_word, wb_req.dat, wb_req.sel);

    always_comb begin
        cfg1_word = `CFG_RESET;
        cfg1_word[`CFG1_CORR_EN_BIT] = corr_en_r;
        cfg1_word[`CFG1_ONCHIP_EN_BIT] = onchip_en_r;
        cfg14_word = `CFG_RESET;
        cfg14_word[`CFG14_LOW_SEL_BIT] = low_sel_r;
    end

    always_comb begin
        rd_data = '0;
        if (reg_hit(wb_req.adr, `IDX_CFG1)) begin
            rd_data[23:0] = cfg1_word;
        end
        if (reg_hit(wb_req.adr, `IDX_CFG8)) begin
            rd_data[23:0] = gain_r;
        end
        if (reg_hit(wb_req.adr, `IDX_CFG9)) begin
            rd_data[23:0] = offset_r;
        end
        if (reg_hit(wb_req.adr, `IDX_CFG14)) begin
            rd_data[23:0] = cfg14_word;
        end
        if (reg_hit(wb_req.adr, `IDX_RESULT)) begin
            rd_data[RW-1:0] = result_r;
        end
        if (reg_hit(wb_req.adr, `IDX_STATUS)) begin
            rd_data[`STAT_BUSY_BIT] = state_r != ST_IDLE;
            rd_data[`STAT_VALID_BIT] = valid_r;
            rd_data[`STAT_SAT_BIT] = sat_r;
        end
    end

    // unmapped reads return zero, unmapped writes are dropped
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end else begin
            ack_r <= bus_req;
            dat_r <= (bus_req && !wb_req.we) ? rd_data : '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            onchip_en_r <= 1'b0;
            corr_en_r <= 1'b0;
            low_sel_r <= 1'b0;
            gain_r <= `CFG_RESET;
            offset_r <= `CFG_RESET;
        end else if (wr_req) begin
            if (reg_hit(wb_req.adr, `IDX_CFG1)) begin
                onchip_en_r <= cfg1_merged[`CFG1_ONCHIP_EN_BIT];
                corr_en_r <= cfg1_merged[`CFG1_CORR_EN_BIT];
            end
            if (reg_hit(wb_req.adr, `IDX_CFG8)) begin
                gain_r <= merge_bytes(gain_r, wb_req.dat, wb_req.sel);
            end
            if (reg_hit(wb_req.adr, `IDX_CFG9)) begin
                offset_r <= merge_bytes(offset_r, wb_req.dat, wb_req.sel);
            end
            if (reg_hit(wb_req.adr, `IDX_CFG14)) begin
                low_sel_r <= cfg14_merged[`CFG14_LOW_SEL_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // measurement sequence
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (cycle_end && onchip_en_r) state_nxt = ST_REF;
            ST_REF: if (started_r && discharge_done) state_nxt = ST_SER;
            ST_SER: if (started_r && discharge_done) state_nxt = ST_DIV;
            ST_DIV: if (div_done) state_nxt = ST_STORE;
            ST_STORE: state_nxt = ST_IDLE;
        endcase
        // clearing the enable abandons a run without storing
        if (!onchip_en_r) begin
            state_nxt = ST_IDLE;
        end
    end

    assign fire = ((state_r == ST_REF) || (state_r == ST_SER)) && !started_r
                  && (applied == route_r) && (route_r != ROUTE_OPEN);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            route_r <= ROUTE_OPEN;
            started_r <= 1'b0;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            start_r <= fire && (state_nxt == state_r);
            if (state_nxt == ST_REF) begin
                route_r <= ROUTE_REF;
            end else if (state_nxt == ST_SER) begin
                route_r <= ROUTE_SER;
            end else begin
                route_r <= ROUTE_OPEN;
            end
            if (state_nxt != state_r) begin
                started_r <= 1'b0;
            end else if (fire) begin
                started_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            t_ref_r <= '0;
            t_ser_r <= '0;
            div_start_r <= 1'b0;
        end else begin
            if (state_r == ST_REF && state_nxt == ST_SER) begin
                t_ref_r <= discharge_time;
            end
            if (state_r == ST_SER && state_nxt == ST_DIV) begin
                t_ser_r <= discharge_time;
            end
            div_start_r <= (state_r == ST_SER) && (state_nxt == ST_DIV);
        end
    end

    // ser/ref = 1 + rtemp/rsg, so the fraction is (ser - ref) / ref
    assign diff = (t_ser_r > t_ref_r) ? t_ser_r - t_ref_r : '0;
    assign numer = {diff, {`RATIO_FRAC_BITS{1'b0}}};

    tempseq_ratio_div #(
        .NW(NW),
        .DW(TW),
        .QW(RW)
    ) u_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(div_start_r),
        .numer(numer),
        .denom(t_ref_r),
        .done(div_done),
        .quot(div_quot),
        .sat(div_sat)
    );

    tempseq_switch_drive u_switch (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .route(route_r),
        .switches(switches),
        .applied(applied)
    );

    // ------------------------------------------------------------
    // results and controls
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            result_r <= `RESULT_RESET;
            valid_r <= 1'b0;
            sat_r <= 1'b0;
            update_r <= 1'b0;
        end else begin
            update_r <= (state_r == ST_STORE)
                        || (state_r == ST_IDLE && cycle_end && !onchip_en_r);
            if (state_r == ST_STORE) begin
                result_r <= div_quot;
                valid_r <= 1'b1;
                sat_r <= div_sat;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sel_out_r <= 1'b0;
            corr_out_r <= 1'b0;
            low_out_r <= 1'b0;
            gain_out_r <= `CFG_RESET;
            offset_out_r <= `CFG_RESET;
        end else begin
            sel_out_r <= onchip_en_r;
            corr_out_r <= corr_en_r;
            low_out_r <= low_sel_r;
            gain_out_r <= corr_en_r ? gain_r : `CFG_RESET;
            offset_out_r <= corr_en_r ? offset_r : `CFG_RESET;
        end
    end

    assign wb_dat_r = dat_r;
    assign wb_ack = ack_r;
    assign discharge_start = start_r;
    assign results_update = update_r;
    assign temp_resistor_low_select = low_out_r;
    assign onchip_temp_select = sel_out_r;
    assign temp_correction_en = corr_out_r;
    assign gain_drift_factor = gain_out_r;
    assign offset_drift_factor = offset_out_r;
    assign temp_result = result_r;
endmodule

//--- sim/bridge_discharge_model.sv
// behavioural bridge gauges and on-chip resistors answering discharge requests
`timescale 1ns/1ps
module bridge_discharge_model #(
    parameter int RSG = 350,
    parameter int TPO = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // discharge handshake
    input wire logic discharge_start,
    input wire logic slow,
    output logic discharge_done,
    output logic [23:0] discharge_time,
    // switch and resistor state
    input wire tempseq_pkg::switch_set_s switches,
    input wire logic temp_resistor_low_select
);
    import tempseq_pkg::*;
    logic busy_r;
    logic [7:0] cnt_r;
    logic [23:0] hold_r;
    int r_tmp;
    int t_ref;
    int t_ser;
    assign r_tmp = temp_resistor_low_select ? 300 : 600;
    assign t_ref = RSG * TPO;
    assign t_ser = (RSG + r_tmp) * TPO;
    always_ff @(posedge core_clk) begin
        discharge_done <= 1'b0;
        // time lines toggle whenever out of reset and no answer is being given
        discharge_time <= ~discharge_time;
        if (!rst_n) begin
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
            hold_r <= 24'h000000;
            discharge_time <= 24'h5a5a5a;
        end else if (discharge_start) begin
            busy_r <= 1'b1;
            cnt_r <= slow ? 8'h28 : 8'h02;
            // an unknown switch pattern gives a useless time
            hold_r <= (switches == 4'h3) ? 24'(t_ser) :
                      (switches == 4'hc) ? 24'(t_ref) : 24'h000000;
        end else if (busy_r && cnt_r == 8'h00) begin
            busy_r <= 1'b0;
            discharge_done <= 1'b1;
            discharge_time <= hold_r;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
endmodule

//--- sim/tempseq_assertions.sv
// concurrent checks on the ports of the temperature ratio sequencer
`timescale 1ns/1ps
module tempseq_checker #(
    parameter int TW = 24,
    parameter int RW = 24
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register bus
    input wire tempseq_pkg::wb_req_s wb_req,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    // converter timing
    input wire logic cycle_end,
    input wire logic discharge_done,
    input wire logic [TW-1:0] discharge_time,
    input wire logic discharge_start,
    input wire logic results_update,
    // switches, controls and result
    input wire tempseq_pkg::switch_set_s switches,
    input wire logic temp_resistor_low_select,
    input wire logic onchip_temp_select,
    input wire logic temp_correction_en,
    input wire logic [23:0] gain_drift_factor,
    input wire logic [23:0] offset_drift_factor,
    input wire logic [RW-1:0] temp_result
);
    import tempseq_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_ack_after_req:
        assert property (wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack)
        else $error("bus request not answered next cycle");
    a_ack_single:
        assert property (wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
    a_idle_data_zero:
        assert property (!wb_ack |-> wb_dat_r == 32'h0) else $error("read data without ack");
    a_start_on_route:
        assert property (discharge_start |-> switches == 4'hc || switches == 4'h3)
        else $error("discharge started without a valid route");
    a_break_before_make:
        assert property (switches.c_direct |=> !switches.c_series)
        else $error("series route made while direct route closed");
    a_result_with_update:
        assert property (!$stable(temp_result) |-> results_update || $past(results_update))
        else $error("result changed without update pulse");
    a_factor_gate:
        assert property (!temp_correction_en && !$past(temp_correction_en) |->
            gain_drift_factor == 24'h0 && offset_drift_factor == 24'h0)
        else $error("drift factors passed while correction off");
    a_disabled_quiet:
        assert property ((!onchip_temp_select)[*3] |-> switches == 4'h0 && !discharge_start)
        else $error("discharge activity while measurement disabled");
    c_measure: cover property (results_update && onchip_temp_select);
    c_series: cover property (discharge_start && switches.c_series);
    c_read: cover property (wb_ack && !wb_req.we);
endmodule
bind onchip_temperature_ratio_sequencer tempseq_checker #(.TW(TW), .RW(RW)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .cycle_end(cycle_end), .discharge_done(discharge_done),
    .discharge_time(discharge_time), .discharge_start(discharge_start),
    .results_update(results_update), .switches(switches),
    .temp_resistor_low_select(temp_resistor_low_select),
    .onchip_temp_select(onchip_temp_select), .temp_correction_en(temp_correction_en),
    .gain_drift_factor(gain_drift_factor), .offset_drift_factor(offset_drift_factor),
    .temp_result(temp_result));

//--- sim/testbench.sv
// self-checking bench for the temperature ratio sequencer
`timescale 1ns/1ps
module testbench;
    import tempseq_pkg::*;
    localparam int RSG = 350;
    localparam int TPO = 16;
    logic core_clk, rst_n, cycle_end, slow, wb_ack, discharge_done, discharge_start;
    logic results_update, temp_resistor_low_select, onchip_temp_select, temp_correction_en;
    logic [31:0] wb_dat_r, q;
    logic [23:0] discharge_time, gain_drift_factor, offset_drift_factor, temp_result;
    wb_req_s wb_req;
    switch_set_s switches;
    int failures, checked;
    int starts = 0;
    int updates = 0;
    onchip_temperature_ratio_sequencer DUT (.core_clk(core_clk), .rst_n(rst_n),
        .wb_req(wb_req), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .cycle_end(cycle_end),
        .discharge_done(discharge_done), .discharge_time(discharge_time),
        .discharge_start(discharge_start), .results_update(results_update),
        .switches(switches), .temp_resistor_low_select(temp_resistor_low_select),
        .onchip_temp_select(onchip_temp_select), .temp_correction_en(temp_correction_en),
        .gain_drift_factor(gain_drift_factor), .offset_drift_factor(offset_drift_factor),
        .temp_result(temp_result));
    bridge_discharge_model #(.RSG(RSG), .TPO(TPO)) u_bridge (.core_clk(core_clk),
        .rst_n(rst_n), .discharge_start(discharge_start), .slow(slow),
        .discharge_done(discharge_done), .discharge_time(discharge_time),
        .switches(switches), .temp_resistor_low_select(temp_resistor_low_select));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (discharge_start === 1'b1) starts++;
        if (results_update === 1'b1) updates++;
    end
    // ----
    // helpers
    // ----
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic timed_out;
        failures++;
        $display("mismatch at %0t: wait ran out", $time);
        close_out();
    endtask
    task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, d};
        @(posedge core_clk);
        while (wb_ack !== 1'b1) begin
            n++;
            if (n > 20) timed_out();
            @(posedge core_clk);
        end
        q = wb_dat_r;
        wb_req <= '0;
    endtask
    task automatic pulse_end;
        @(posedge core_clk);
        cycle_end <= 1'b1;
        @(posedge core_clk);
        cycle_end <= 1'b0;
    endtask
    function automatic logic [31:0] exp_ratio(input logic low);
        longint t_ref;
        longint t_ser;
        t_ref = RSG * TPO;
        t_ser = (RSG + (low ? 300 : 600)) * TPO;
        return 32'(((t_ser - t_ref) << 20) / t_ref);
    endfunction
    // ----
    // scenarios
    // ----
    task automatic s_reset_values;
        wb(1'b0, 12'h3d4, 32'h0);
        cmp(q, 32'h0);
        wb(1'b1, 12'h100, 32'h00ffffff);
        wb(1'b0, 12'h100, 32'h0);
        cmp(q, 32'h0);
    endtask
    task automatic s_correction;
        wb(1'b1, 12'h020, 32'h00123456);
        wb(1'b1, 12'h024, 32'h00abcdef);
        repeat (2) @(posedge core_clk);
        cmp({8'h0, gain_drift_factor}, 32'h0);
        wb(1'b1, 12'h004, 32'h00000040);
        repeat (2) @(posedge core_clk);
        cmp({31'h0, temp_correction_en}, 32'h1);
        cmp({8'h0, gain_drift_factor}, 32'h00123456);
        cmp({8'h0, offset_drift_factor}, 32'h00abcdef);
    endtask
    task automatic s_measure(input logic low, input logic sl);
        int s0;
        slow <= sl;
        wb(1'b1, 12'h038, {31'h0, low});
        wb(1'b1, 12'h004, 32'h00000100);
        repeat (2) @(posedge core_clk);
        cmp({31'h0, temp_resistor_low_select}, {31'h0, low});
        cmp({31'h0, onchip_temp_select}, 32'h1);
        s0 = starts;
        pulse_end();
        begin
            int n;
            n = 0;
            @(posedge core_clk);
            while (results_update !== 1'b1) begin
                n++;
                if (n > 800) timed_out();
                @(posedge core_clk);
            end
        end
        repeat (2) @(posedge core_clk);
        cmp(32'(starts - s0), 32'h2);
        cmp({8'h0, temp_result}, exp_ratio(low));
        wb(1'b0, 12'h3d4, 32'h0);
        cmp(q, exp_ratio(low));
        wb(1'b0, 12'h3d8, 32'h0);
        cmp(q & 32'h7, 32'h2);
    endtask
    task automatic s_disabled;
        int s0;
        logic [23:0] r0;
        wb(1'b1, 12'h004, 32'h0);
        s0 = starts;
        r0 = temp_result;
        pulse_end();
        @(posedge core_clk);
        cmp({31'h0, results_update}, 32'h1);
        repeat (30) @(posedge core_clk);
        cmp({31'h0, onchip_temp_select}, 32'h0);
        cmp(32'(starts - s0), 32'h0);
        cmp({8'h0, temp_result}, {8'h0, r0});
    endtask
    task automatic s_abort;
        int s0;
        int u0;
        int n;
        logic [23:0] r0;
        slow <= 1'b1;
        wb(1'b1, 12'h004, 32'h00000100);
        s0 = starts;
        u0 = updates;
        r0 = temp_result;
        pulse_end();
        n = 0;
        while (starts == s0) begin
            n++;
            if (n > 50) timed_out();
            @(posedge core_clk);
        end
        wb(1'b1, 12'h004, 32'h0);
        repeat (150) @(posedge core_clk);
        cmp(32'(updates - u0), 32'h0);
        cmp({8'h0, temp_result}, {8'h0, r0});
        cmp({28'h0, switches}, 32'h0);
    endtask
    initial begin
        rst_n = 1'b0;
        cycle_end = 1'b0;
        slow = 1'b0;
        wb_req = '0;
        q = 32'h0;
        failures = 0;
        checked = 0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        s_reset_values();
        s_correction();
        s_measure(1'b1, 1'b0);
        s_measure(1'b0, 1'b1);
        s_disabled();
        s_abort();
        s_measure(1'b1, 1'b0);
        close_out();
    end
endmodule
